// ### logic/dual_timer.sv
`timescale 1ns/1ps
`include "dual_timer_defs.svh"
module dual_timer (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [11:0] AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [11:0] ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        EVENT_PIN_ZERO_I,
  input  wire logic        EVENT_PIN_ONE_I,
  input  wire logic        GATE_INPUT_ZERO_I,
  input  wire logic        GATE_INPUT_ONE_I,
  input  wire logic        EXT_CLK_I,
  input  wire logic        VECTOR_ACK_ZERO_I,
  input  wire logic        VECTOR_ACK_ONE_I,
  output logic             IRQ_ZERO_O,
  output logic             IRQ_ONE_O,
  output logic             T1_OVERFLOW_O,
  output logic             SECOND_TIMER_HIGH_CLK_SEL_O,
  output logic             SECOND_TIMER_LOW_CLK_SEL_O,
  output logic             THIRD_TIMER_HIGH_CLK_SEL_O,
  output logic             THIRD_TIMER_LOW_CLK_SEL_O
);
  import dual_timer_pkg::*;

  logic [7:0]  clk_sel_r;
  logic [7:0]  mode_r;
  logic [3:0]  irq_cfg_r;
  logic        tr0_r, tr1_r, tf0_r, tf1_r;
  logic [7:0]  tl0_r, th0_r, tl1_r, th1_r;
  logic [11:0] awaddr_r;
  logic        aw_full_r;
  logic [7:0]  wdata_r;
  logic        wbyte_r;
  logic        w_full_r;
  logic        do_write;
  logic [5:0]  div_r;
  logic [5:0]  div_lim;
  logic        div_adv;
  logic        presc_tick;
  logic [4:0]  pin_lvl, pin_fall, pin_rise;
  tmr_mode_t   m0, m1;
  logic        split;
  logic        t0_clk, t1_clk;
  logic        t0_run, t1_run, th0_run;
  logic        t0_go, t1_go, th0_go;
  logic        g0_act, g1_act;
  logic [16:0] t0_nxt, t1_nxt;
  logic        t0_ovf, th0_ovf, t1_ovf;
  logic        set_tf0, set_tf1;
  logic        wr_ctl, wr_mode, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_ck, wr_irq;
  logic [7:0]  rd_val;
  logic        rd_hit;

  // register index decode, shared by read and write
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx);
  endfunction
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[11:2] >= `IDX_RUN_FLAG) && (a[11:2] <= `IDX_IRQ_CFG);
  endfunction
  // one count step: {overflow, high, low}
  function automatic logic [16:0] step(input tmr_mode_t m,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    unique case (m)
      MODE_13BIT:  step = {({hi, lo[4:0]} == 13'h1FFF), c13[12:5],
                           lo[7:5], c13[4:0]};
      MODE_16BIT:  step = {(c16 == 16'h0000), c16};
      MODE_RELOAD: step = (lo == 8'hFF) ? {1'b1, hi, hi}
                                        : {1'b0, hi, lo + 8'h01};
      MODE_SPLIT:  step = (lo == 8'hFF) ? {1'b1, hi, 8'h00}
                                        : {1'b0, hi, lo + 8'h01};
    endcase
  endfunction
  // input synchronisers: event0, event1, timer_zero_gate_enable, gate1, external clock
  pin_sync #(.N(5)) u_sync (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .pin_i   ({EXT_CLK_I, GATE_INPUT_ONE_I, GATE_INPUT_ZERO_I,
               EVENT_PIN_ONE_I, EVENT_PIN_ZERO_I}),
    .level_o (pin_lvl),
    .fall_o  (pin_fall),
    .rise_o  (pin_rise)
  );
  // axi write channels, either order
  assign AWREADY_O = ~aw_full_r & ~BVALID_O;
  assign WREADY_O  = ~w_full_r & ~BVALID_O;
  assign do_write  = aw_full_r & w_full_r & ~BVALID_O;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 8'h00;
      wbyte_r   <= 1'b0;
      BVALID_O  <= 1'b0;
      BRESP_O   <= `RESP_OKAY;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_full_r <= 1'b1;
        wdata_r  <= WDATA_I[7:0];
        wbyte_r  <= WSTRB_I[0];
      end
      if (do_write) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        BVALID_O  <= 1'b1;
        BRESP_O   <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end
  // write strobes per register, low byte lane only
  always_comb begin
    wr_ctl  = do_write & wbyte_r & hit(awaddr_r, `IDX_RUN_FLAG);
    wr_mode = do_write & wbyte_r & hit(awaddr_r, `IDX_MODE);
    wr_tl0  = do_write & wbyte_r & hit(awaddr_r, `IDX_T0_LOW);
    wr_th0  = do_write & wbyte_r & hit(awaddr_r, `IDX_T0_HIGH);
    wr_tl1  = do_write & wbyte_r & hit(awaddr_r, `IDX_T1_LOW);
    wr_th1  = do_write & wbyte_r & hit(awaddr_r, `IDX_T1_HIGH);
    wr_ck   = do_write & wbyte_r & hit(awaddr_r, `IDX_CLK_SEL);
    wr_irq  = do_write & wbyte_r & hit(awaddr_r, `IDX_IRQ_CFG);
  end

  // read mux
  always_comb begin
    rd_hit = mapped(ARADDR_I);
    rd_val = 8'h00;
    if (hit(ARADDR_I, `IDX_RUN_FLAG))
      rd_val = {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
    if (hit(ARADDR_I, `IDX_MODE))    rd_val = mode_r;
    if (hit(ARADDR_I, `IDX_T0_LOW))  rd_val = tl0_r;
    if (hit(ARADDR_I, `IDX_T0_HIGH)) rd_val = th0_r;
    if (hit(ARADDR_I, `IDX_T1_LOW))  rd_val = tl1_r;
    if (hit(ARADDR_I, `IDX_T1_HIGH)) rd_val = th1_r;
    if (hit(ARADDR_I, `IDX_CLK_SEL)) rd_val = clk_sel_r;
    if (hit(ARADDR_I, `IDX_IRQ_CFG)) rd_val = {4'h0, irq_cfg_r};
  end

  // axi read channel
  assign ARREADY_O = ~RVALID_O;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= 32'h0000_0000;
      RRESP_O  <= `RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      RVALID_O <= 1'b1;
      RDATA_O  <= {24'h00_0000, rd_val};
      RRESP_O  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clk_sel_r <= `RST_BYTE;
      mode_r    <= `RST_BYTE;
      irq_cfg_r <= 4'h0;
      tr0_r     <= 1'b0;
      tr1_r     <= 1'b0;
    end else begin
      if (wr_ck)   clk_sel_r <= wdata_r;
      if (wr_mode) mode_r    <= wdata_r;
      if (wr_irq)  irq_cfg_r <= wdata_r[3:0];
      if (wr_ctl) begin
        tr0_r <= wdata_r[`F_TR0];
        tr1_r <= wdata_r[`F_TR1];
      end
    end
  end

  // clock choices exported to the other timers
  assign SECOND_TIMER_HIGH_CLK_SEL_O = clk_sel_r[`F_T2H];
  assign SECOND_TIMER_LOW_CLK_SEL_O  = clk_sel_r[`F_T2L];
  assign THIRD_TIMER_HIGH_CLK_SEL_O  = clk_sel_r[`F_T3H];
  assign THIRD_TIMER_LOW_CLK_SEL_O   = clk_sel_r[`F_T3L];

  // prescaler ratio and advance source
  always_comb begin
    unique case (clk_sel_r[1:0])
      2'b00: div_lim = `DIV_SYS12;
      2'b01: div_lim = `DIV_SYS4;
      2'b10: div_lim = `DIV_SYS48;
      2'b11: div_lim = `DIV_EXT8;
    endcase
    div_adv = (clk_sel_r[1:0] == 2'b11) ? pin_rise[4] : 1'b1;
  end
  assign presc_tick = div_adv & (div_r >= div_lim - 6'd1);

  // prescaler counter
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_r <= 6'd0;
    end else if (div_adv) begin
      div_r <= presc_tick ? 6'd0 : div_r + 6'd1;
    end
  end

  // clock, gate and run decode
  always_comb begin
    m0     = tmr_mode_t'(mode_r[1:0]);
    m1     = tmr_mode_t'(mode_r[5:4]);
    split  = (m0 == MODE_SPLIT);
    g0_act = pin_lvl[2] == irq_cfg_r[`F_POL0];
    g1_act = pin_lvl[3] == irq_cfg_r[`F_POL1];
    t0_clk = clk_sel_r[`F_T0M] ? 1'b1 : presc_tick;
    t1_clk = clk_sel_r[`F_T1M] ? 1'b1 : presc_tick;
    t0_run = tr0_r & (~mode_r[`F_GATE] | g0_act);
    t0_go  = t0_run & (mode_r[`F_CT] ? pin_fall[0] : t0_clk);
    th0_run = split & tr1_r;
    th0_go  = th0_run & t0_clk;
    if (m1 == MODE_SPLIT) begin
      t1_run = 1'b0;
      t1_go  = 1'b0;
    end else if (split) begin
      t1_run = 1'b1;
      t1_go  = t1_clk;
    end else begin
      t1_run = tr1_r & (~mode_r[4+`F_GATE] | g1_act);
      t1_go  = t1_run & (mode_r[4+`F_CT] ? pin_fall[1] : t1_clk);
    end
  end

  // next counts and overflow events
  always_comb begin
    t0_nxt  = step(m0, th0_r, tl0_r);
    t1_nxt  = step(m1, th1_r, tl1_r);
    t0_ovf  = t0_go & t0_nxt[16];
    th0_ovf = th0_go & (th0_r == 8'hFF);
    t1_ovf  = t1_go & t1_nxt[16];
    set_tf0 = t0_ovf;
    set_tf1 = split ? th0_ovf : t1_ovf;
  end

  // timer zero count, software write takes precedence
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tl0_r <= 8'h00;
      th0_r <= 8'h00;
    end else begin
      if (wr_tl0)      tl0_r <= wdata_r;
      else if (t0_go)  tl0_r <= t0_nxt[7:0];
      if (wr_th0)      th0_r <= wdata_r;
      else if (split && th0_go) th0_r <= th0_r + 8'h01;
      else if (!split && t0_go) th0_r <= t0_nxt[15:8];
    end
  end

  // timer one count
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tl1_r <= 8'h00;
      th1_r <= 8'h00;
    end else begin
      if (wr_tl1)     tl1_r <= wdata_r;
      else if (t1_go) tl1_r <= t1_nxt[7:0];
      if (wr_th1)     th1_r <= wdata_r;
      else if (t1_go) th1_r <= t1_nxt[15:8];
    end
  end

  // overflow flags, a set beats a clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tf0_r <= 1'b0;
      tf1_r <= 1'b0;
      T1_OVERFLOW_O <= 1'b0;
    end else begin
      tf0_r <= set_tf0 | ((wr_ctl ? wdata_r[`F_TF0] : tf0_r)
               & ~VECTOR_ACK_ZERO_I);
      tf1_r <= set_tf1 | ((wr_ctl ? wdata_r[`F_TF1] : tf1_r)
               & ~VECTOR_ACK_ONE_I);
      T1_OVERFLOW_O <= t1_ovf;
    end
  end

  // interrupt requests
  assign IRQ_ZERO_O = tf0_r & irq_cfg_r[`F_ET0];
  assign IRQ_ONE_O  = tf1_r & irq_cfg_r[`F_ET1];

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_flag_zero_set: assert property (t0_ovf |=> tf0_r && IRQ_ZERO_O == irq_cfg_r[`F_ET0])
    else $error("timer zero overflow did not set flag");
  a_wrap_13bit: assert property (m0 == MODE_13BIT && t0_go && !wr_tl0 && !wr_th0
      && th0_r == 8'hFF && tl0_r[4:0] == 5'h1F |=> th0_r == 8'h00 && tl0_r[4:0] == 5'h00)
    else $error("13-bit wrap wrong");
  a_reload_copy: assert property (m0 == MODE_RELOAD && t0_ovf && !wr_tl0 && !wr_th0
      |=> tl0_r == th0_r && $stable(th0_r))
    else $error("reload did not copy high byte");
  a_hold_stopped: assert property (!tr0_r && !wr_tl0 && !wr_th0 && !split
      |=> $stable(tl0_r) && $stable(th0_r))
    else $error("stopped timer changed");
  a_count_event: assert property (m0 == MODE_16BIT && mode_r[`F_CT] && t0_run
      && pin_fall[0] && !wr_tl0 && !wr_th0
      |=> {th0_r, tl0_r} == $past({th0_r, tl0_r}) + 16'h0001)
    else $error("event edge not counted");
  a_split_flag: assert property (th0_ovf |=> tf1_r)
    else $error("split high byte did not set timer one flag");
  a_split_t1_quiet: assert property (split && !th0_ovf && !tf1_r && !wr_ctl
      |=> !tf1_r)
    else $error("timer one set flag while split");
  a_t1_mode3_stop: assert property (m1 == MODE_SPLIT && !wr_tl1 && !wr_th1
      |=> $stable(tl1_r) && $stable(th1_r))
    else $error("timer one ran in mode 3");
  a_presc_period: assert property (clk_sel_r[1:0] == 2'b01 && presc_tick && !wr_ck
      ##1 !wr_ck [*3] |=> presc_tick && !$past(presc_tick) && !$past(presc_tick, 2)
      && !$past(presc_tick, 3))
    else $error("divide by four period wrong");
  a_ack_clears: assert property (VECTOR_ACK_ZERO_I && !set_tf0 && !wr_ctl |=> !tf0_r)
    else $error("vector acknowledge did not clear flag");

  c_ovf_zero:   cover property (t0_ovf && m0 == MODE_16BIT);
  c_reload:     cover property (t0_ovf && m0 == MODE_RELOAD);
  c_split_tf1:  cover property (th0_ovf);
  c_ext_presc:  cover property (presc_tick && clk_sel_r[1:0] == 2'b11);
endmodule

// ### logic/dual_timer_defs.svh
`ifndef DUAL_TIMER_DEFS_SVH
`define DUAL_TIMER_DEFS_SVH

// register indices, byte address is four times the index
`define IDX_RUN_FLAG  10'h088
`define IDX_MODE      10'h089
`define IDX_T0_LOW    10'h08A
`define IDX_T1_LOW    10'h08B
`define IDX_T0_HIGH   10'h08C
`define IDX_T1_HIGH   10'h08D
`define IDX_CLK_SEL   10'h08E
`define IDX_IRQ_CFG   10'h08F

// run/flag register fields
`define F_TF1 7
`define F_TR1 6
`define F_TF0 5
`define F_TR0 4
// mode register fields, timer one in the upper nibble
`define F_GATE 3
`define F_CT   2
// clock-select fields
`define F_T3H  7
`define F_T3L  6
`define F_T2H  5
`define F_T2L  4
`define F_T1M  3
`define F_T0M  2
// irq config fields
`define F_ET0  0
`define F_ET1  1
`define F_POL0 2
`define F_POL1 3

`define RST_BYTE 8'h00

// prescaler ratios
`define DIV_SYS12 6'd12
`define DIV_SYS4  6'd4
`define DIV_SYS48 6'd48
`define DIV_EXT8  6'd8

`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// ### logic/dual_timer_pkg.sv
package dual_timer_pkg;
  // timer operating modes
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } tmr_mode_t;
endpackage

// ### logic/pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with falling and rising edge pulses
module pin_sync #(
  parameter int N = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] pin_i,
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] fall_o,
  output logic      [N-1:0] rise_o
);
  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] prev_r;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= pin_i[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
      assign level_o[g] = sync_r[g];
      assign fall_o[g]  = prev_r[g] & ~sync_r[g];
      assign rise_o[g]  = ~prev_r[g] & sync_r[g];
    end
  endgenerate
endmodule

// ### testbench/event_source.sv
`timescale 1ns/1ps
// far side: event pins, gate levels and a free-running external clock
module event_source (
  input  wire logic clk_i,
  output logic      ev0_o,
  output logic      ev1_o,
  output logic      g0_o,
  output logic      g1_o,
  output logic      ext_clk_o
);
  int ph;

  // idle levels: event pins high, gates low, the active level for a gate whose polarity bit is clear
  initial begin
    ev0_o     = 1'b1;
    ev1_o     = 1'b1;
    g0_o      = 1'b0;
    g1_o      = 1'b0;
    ext_clk_o = 1'b0;
    ph        = 0;
  end

  // external oscillator, six system clocks per period
  always @(posedge clk_i) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2) ext_clk_o <= ~ext_clk_o;
  end

  // n falling edges, each low level held three clocks, each high level at least three
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (pin == 0) ev0_o <= 1'b0; else ev1_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (pin == 0) ev0_o <= 1'b1; else ev1_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
  endtask

  // gate level change
  task automatic set_gate(input int pin, input logic lvl);
    @(posedge clk_i);
    if (pin == 0) g0_o <= lvl; else g1_o <= lvl;
  endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "dual_timer_defs.svh"
module testbench;
  import dual_timer_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ack0, ack1;
  logic        awready, wready, bvalid, arready, rvalid, irq0, irq1, ovf_one;
  logic        ev0, ev1, g0, g1, ext_clk;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  csel, wstrb;
  int          n_errors, n_compared;

  dual_timer u_dual_timer (.CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .EVENT_PIN_ZERO_I(ev0), .EVENT_PIN_ONE_I(ev1), .GATE_INPUT_ZERO_I(g0),
    .GATE_INPUT_ONE_I(g1), .EXT_CLK_I(ext_clk), .VECTOR_ACK_ZERO_I(ack0),
    .VECTOR_ACK_ONE_I(ack1), .IRQ_ZERO_O(irq0), .IRQ_ONE_O(irq1),
    .T1_OVERFLOW_O(ovf_one), .SECOND_TIMER_HIGH_CLK_SEL_O(csel[1]),
    .SECOND_TIMER_LOW_CLK_SEL_O(csel[0]), .THIRD_TIMER_HIGH_CLK_SEL_O(csel[3]),
    .THIRD_TIMER_LOW_CLK_SEL_O(csel[2]));
  event_source u_event_source (.clk_i(clk), .ev0_o(ev0), .ev1_o(ev1), .g0_o(g0),
    .g1_o(g1), .ext_clk_o(ext_clk));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tmo(input string what);
    n_errors++;
    $display("Error %s expected handshake seen timeout", what);
    close_out();
  endtask

  // AXI4-Lite write of one byte register, response left in resp
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic a, w, b;
    int   n;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b) begin
      @(negedge clk);
      a = awready & awvalid;
      w = wready & wvalid;
      b = bvalid;
      resp = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      n++;
      if (n > 40) tmo("bvalid");
    end
    bready <= 1'b0;
  endtask

  // AXI4-Lite read, data in rd_val and response in resp
  task automatic rd(input logic [9:0] idx);
    logic a, r;
    int   n;
    n = 0;
    r = 1'b0;
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r) begin
      @(negedge clk);
      a = arready & arvalid;
      r = rvalid;
      rd_val = rdata;
      resp = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'b0;
      n++;
      if (n > 40) tmo("rvalid");
    end
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp, input string what);
    rd(idx);
    check(what, rd_val, {24'h000000, exp});
  endtask

  // poll the run/flag register until a flag bit sets
  task automatic wait_flag(input int bit_no);
    int n;
    n = 0;
    do begin
      rd(`IDX_RUN_FLAG);
      n++;
      if (n > 400) tmo("overflow flag");
    end while (rd_val[bit_no] !== 1'b1);
  endtask

  // count overflow pulses of timer one over a number of cycles
  task automatic count_ovf(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (ovf_one === 1'b1) cnt++;
    end
  endtask

  task automatic t_reset();
    for (int i = 'h88; i <= 'h8F; i++) rdc(i[9:0], 8'h00, "reset value");
    check("clock routes at reset", {28'h0, csel}, 32'h0);
    rdc(10'h090, 8'h00, "unmapped read data");
    check("unmapped read resp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(10'h091, 8'h5A);
    check("unmapped write resp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
  endtask

  task automatic t_routes();
    logic [7:0] v [3] = '{8'hF0, 8'hA0, 8'h50};
    foreach (v[i]) begin
      wr(`IDX_CLK_SEL, v[i]);
      rdc(`IDX_CLK_SEL, v[i], "clock select readback");
      check("clock routes", {28'h0, csel}, {28'h0, v[i][7:4]});
    end
    // a write with the low byte lane off must leave the register alone
    wstrb <= 4'h0;
    wr(`IDX_CLK_SEL, 8'h0F);
    wstrb <= 4'hF;
    rdc(`IDX_CLK_SEL, 8'h50, "strobe-less write ignored");
    check("clock routes kept", {28'h0, csel}, 32'h5);
  endtask

  task automatic t_mode1_irq();
    wr(`IDX_IRQ_CFG, 8'h00);
    wr(`IDX_MODE, {6'h00, MODE_16BIT});
    wr(`IDX_T0_HIGH, 8'hFF);
    wr(`IDX_T0_LOW, 8'hF0);
    wr(`IDX_CLK_SEL, 8'h04);
    wr(`IDX_RUN_FLAG, 8'h10);
    wait_flag(`F_TF0);
    check("irq zero masked", {31'h0, irq0}, 32'h0);
    rdc(`IDX_T0_HIGH, 8'h00, "16-bit wrap high byte");
    wr(`IDX_IRQ_CFG, 8'h01);
    @(negedge clk);
    check("irq zero enabled", {31'h0, irq0}, 32'h1);
    @(posedge clk) ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    @(negedge clk);
    check("irq zero after vector", {31'h0, irq0}, 32'h0);
    wr(`IDX_RUN_FLAG, 8'h00);
  endtask

  task automatic t_gate_13bit();
    wr(`IDX_IRQ_CFG, 8'h0A);
    wr(`IDX_MODE, {2'b10, MODE_13BIT, 4'h0});
    wr(`IDX_T1_HIGH, 8'hFF);
    wr(`IDX_T1_LOW, 8'h1E);
    wr(`IDX_CLK_SEL, 8'h08);
    wr(`IDX_RUN_FLAG, 8'h40);
    repeat (20) @(posedge clk);
    rdc(`IDX_T1_LOW, 8'h1E, "gated low byte");
    u_event_source.set_gate(1, 1'b1);
    wait_flag(`F_TF1);
    check("irq one", {31'h0, irq1}, 32'h1);
    rdc(`IDX_T1_HIGH, 8'h00, "13-bit wrap high byte");
    rd(`IDX_T1_LOW);
    check("13-bit wrap low bits", {31'h0, rd_val[4:0] < 5'h18}, 32'h1);
    wr(`IDX_RUN_FLAG, 8'h00);
    rdc(`IDX_RUN_FLAG, 8'h00, "software flag clear");
    check("irq one cleared", {31'h0, irq1}, 32'h0);
    u_event_source.set_gate(1, 1'b0);
  endtask

  task automatic t_reload();
    wr(`IDX_MODE, {2'b00, MODE_16BIT, 2'b10, MODE_RELOAD});
    wr(`IDX_T1_LOW, 8'hFE);
    wr(`IDX_T0_HIGH, 8'hF8);
    wr(`IDX_T0_LOW, 8'hFE);
    wr(`IDX_CLK_SEL, 8'h04);
    wr(`IDX_RUN_FLAG, 8'h10);
    wait_flag(`F_TF0);
    wr(`IDX_RUN_FLAG, 8'h00);
    rdc(`IDX_T0_HIGH, 8'hF8, "reload value kept");
    rd(`IDX_T0_LOW);
    check("reloaded low byte", {31'h0, rd_val[7:0] >= 8'hF8}, 32'h1);
    rdc(`IDX_T1_LOW, 8'hFE, "other timer idle");
  endtask

  task automatic t_events();
    wr(`IDX_MODE, 8'h55);
    wr(`IDX_T0_LOW, 8'h00);
    wr(`IDX_T1_LOW, 8'h00);
    wr(`IDX_CLK_SEL, 8'h0C);
    wr(`IDX_RUN_FLAG, 8'h50);
    u_event_source.pulse(0, 5);
    u_event_source.pulse(1, 3);
    repeat (6) @(posedge clk);
    wr(`IDX_RUN_FLAG, 8'h00);
    rdc(`IDX_T0_LOW, 8'h05, "event count zero");
    rdc(`IDX_T1_LOW, 8'h03, "event count one");
  endtask

  task automatic t_prescale();
    int div [4] = '{12, 4, 48, 48};
    int d;
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_MODE, 8'h01);
      wr(`IDX_CLK_SEL, k[7:0]);
      wr(`IDX_T0_HIGH, 8'h00);
      wr(`IDX_T0_LOW, 8'h00);
      wr(`IDX_RUN_FLAG, 8'h10);
      repeat (480) @(posedge clk);
      wr(`IDX_RUN_FLAG, 8'h00);
      rd(`IDX_T0_LOW);
      d = int'(rd_val[7:0]) - 480 / div[k];
      check("prescaled count", {31'h0, d >= -2 && d <= 2}, 32'h1);
    end
  endtask

  task automatic t_split();
    int cnt;
    wr(`IDX_MODE, {2'b00, MODE_16BIT, 2'b00, MODE_SPLIT});
    wr(`IDX_T1_HIGH, 8'hFF);
    wr(`IDX_T1_LOW, 8'hF0);
    wr(`IDX_T0_HIGH, 8'hF0);
    wr(`IDX_T0_LOW, 8'h00);
    wr(`IDX_CLK_SEL, 8'h0C);
    count_ovf(100, cnt);
    check("timer one overflow while split", cnt, 32'h1);
    rdc(`IDX_RUN_FLAG, 8'h00, "no flag while split");
    rdc(`IDX_T0_HIGH, 8'hF0, "split high held");
    wr(`IDX_MODE, {2'b00, MODE_SPLIT, 2'b00, MODE_SPLIT});
    wr(`IDX_T1_LOW, 8'hF0);
    count_ovf(100, cnt);
    check("timer one stopped", cnt, 32'h0);
    rdc(`IDX_T1_LOW, 8'hF0, "timer one held");
    wr(`IDX_RUN_FLAG, 8'h40);
    wait_flag(`F_TF1);
    @(negedge clk);
    check("irq one from split high byte", {31'h0, irq1}, 32'h1);
    @(posedge clk) ack1 <= 1'b1;
    @(posedge clk) ack1 <= 1'b0;
    @(negedge clk);
    check("irq one after vector", {31'h0, irq1}, 32'h0);
    rdc(`IDX_T0_LOW, 8'h00, "split low held");
    wr(`IDX_RUN_FLAG, 8'h00);
  endtask

  // reset in mid-run must bring registers and routes back to zero
  task automatic t_midreset();
    wr(`IDX_CLK_SEL, 8'hFF);
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check("clock routes after reset", {28'h0, csel}, 32'h0);
    rdc(`IDX_CLK_SEL, 8'h00, "clock select after reset");
    rdc(`IDX_RUN_FLAG, 8'h00, "run flags after reset");
  endtask

  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ack0, ack1} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_routes();
    t_mode1_irq();
    t_gate_13bit();
    t_reload();
    t_events();
    t_prescale();
    t_split();
    t_midreset();
    close_out();
  end
endmodule
